// ### rtl/ctas_map.svh
`ifndef CTAS_MAP_SVH
`define CTAS_MAP_SVH
// Cancellation path codes.
`define CTAS_PATH_MESSAGE_BOX   2'h0
`define CTAS_PATH_MPFIFO   2'h1
`define CTAS_PATH_TXFIFO   2'h2
`define CTAS_PATH_TRANSMIT_QUEUE  2'h3
// Self test geometry defaults and data width.
`define CTAS_ST_PAGES      4
`define CTAS_ST_PAGE_CELLS 16
`define CTAS_ST_LAST_CELLS 8
`define CTAS_ST_WIDTH      32
`endif

// ### rtl/ctas_pkg.sv
package ctas_pkg;
    typedef enum logic [1:0] {
        CTAS_ST_IDLE,
        CTAS_ST_WRITE,
        CTAS_ST_CHECK
    } ctas_st_e;
endpackage

// ### rtl/ctas_abort_selftest.sv
`timescale 1ns/1ns
`default_nettype none
`include "ctas_map.svh"

// How it works
// R1: When a requested cancellation has fully resolved, abort_irq_out pulses for one cycle.
// R2: Message-box path with the wildcard cancels every requesting buffer, otherwise only the named buffer.
// R3: Multi-purpose FIFO path needs a named FIFO; its buffer is cancelled and the FIFO is told to advance.
// R4: Transmit FIFO path ignores the detail and cancels the front-most FIFO entry, then pops it.
// R5: Each buffer shows a request flag and a complete flag that tell sent from withdrawn.
// R6: Software treats the outcome as unknown in reset or sleep, or while the flags are not final.
// R7: Internal-bus mode wires all channels together and holds the external transmit pins recessive.
// R8: Internal-bus mode is entered only while global halt mode is active.
// R9: The RAM self test walks page by page, clearing each cell and then walking a one through it.
// R10: While the self test runs no channel may transmit and the pins stay recessive.
// R11: The self test starts only in global halt mode and any mismatch is reported as a failure.
// R12: After a self test software reconfigures all channels, storage and global settings.
// R13: Software clears request flags of every used buffer before init mode or bus-off recovery.
// R14: A buffer already on the bus is left to finish and reports sent; if it leaves the bus unsent it reports cancelled.
module ctas_abort_selftest #(
    parameter int NBUF  = 8,
    parameter int NFIFO = 2,
    parameter int NCH   = 2,
    parameter int BW    = 3,
    parameter int PAGES = `CTAS_ST_PAGES,
    parameter int CELLS = `CTAS_ST_PAGE_CELLS,
    parameter int LAST  = `CTAS_ST_LAST_CELLS,
    parameter int DW    = `CTAS_ST_WIDTH
) (
    input  wire logic             clk_in,
    input  wire logic             arst_n_in,
    input  wire logic             global_halt_mode_in,
    input  wire logic [NBUF-1:0]  tx_set_in,
    input  wire logic [NBUF-1:0]  tx_busy_in,
    input  wire logic [NBUF-1:0]  tx_sent_in,
    input  wire logic             abort_req_in,
    input  wire logic [1:0]       abort_path_in,
    input  wire logic             abort_any_in,
    input  wire logic [BW-1:0]    abort_detail_in,
    input  wire logic [NFIFO*BW-1:0] mpf_buf_in,
    input  wire logic [BW-1:0]    txf_front_in,
    input  wire logic             ibus_req_in,
    input  wire logic             ibus_exit_in,
    input  wire logic             selftest_start_in,
    input  wire logic [NCH-1:0]   ch_tx_in,
    input  wire logic [NCH-1:0]   can_rx_in,
    output logic [NBUF-1:0]       transmit_request_flag_out,
    output logic [NBUF-1:0]       transmit_complete_flag_out,
    output logic [NBUF-1:0]       outcome_cancelled_out,
    output logic                  abort_busy_out,
    output logic                  abort_irq_out,
    output logic                  abort_error_out,
    output logic [NFIFO-1:0]      mpf_advance_out,
    output logic                  txf_pop_out,
    output logic                  ibus_active_out,
    output logic                  tx_allow_out,
    output logic [NCH-1:0]        ch_rx_out,
    output logic [NCH-1:0]        can_tx_out,
    output logic                  selftest_busy_out,
    output logic                  selftest_fail_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Abort target decode.

    localparam logic [NBUF-1:0] ONE = {{(NBUF-1){1'b0}}, 1'b1};

    logic [NBUF-1:0]  treq_q, done_q, cnl_q, pend_q, pend_d;
    logic             act_q, irq_q, err_q, pop_q;
    logic [NFIFO-1:0] adv_q, fsel_q;
    logic [1:0]       path_q;

    wire [BW-1:0]   mpf_buf  = mpf_buf_in[abort_detail_in*BW +: BW];
    wire            is_box   = abort_path_in == `CTAS_PATH_MESSAGE_BOX;
    wire            is_mpf   = abort_path_in == `CTAS_PATH_MPFIFO;
    wire            is_txf   = abort_path_in == `CTAS_PATH_TXFIFO;
    wire            bad_req  = (abort_path_in == `CTAS_PATH_TRANSMIT_QUEUE) || (is_mpf && abort_any_in)
                             || (is_mpf && 32'(abort_detail_in) >= NFIFO);  // R3
    wire            take     = abort_req_in && !act_q && !bad_req;
    wire [NBUF-1:0] tgt      = is_box ? (abort_any_in ? {NBUF{1'b1}} : ONE << abort_detail_in)  // R2
                             : is_mpf ? ONE << mpf_buf  // R3
                             : is_txf ? ONE << txf_front_in  // R4
                             : '0;
    wire [NBUF-1:0] hit      = take ? (tgt & treq_q) : '0;
    // A frame already on the bus cannot be recalled, so it is left to finish.
    wire [NBUF-1:0] late     = pend_q & ~tx_busy_in & ~tx_sent_in;  // R14
    wire [NBUF-1:0] cancel   = (hit & ~tx_busy_in) | late;
    wire            resolve  = act_q && (pend_d == '0);

    always_comb begin
        pend_d = (pend_q | (hit & tx_busy_in)) & tx_busy_in & ~tx_sent_in;  // R14
    end

    // New request clears the outcome; completion and cancel clear the request.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            treq_q <= '0;
            done_q <= '0;
            cnl_q  <= '0;
            pend_q <= '0;
        end else begin
            treq_q <= (treq_q & ~tx_sent_in & ~cancel) | tx_set_in;  // R5
            done_q <= (done_q & ~tx_set_in) | (tx_sent_in & treq_q);  // R5
            cnl_q  <= (cnl_q & ~tx_set_in) | (cancel & treq_q);
            pend_q <= pend_d;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            act_q  <= 1'b0;
            irq_q  <= 1'b0;
            err_q  <= 1'b0;
            pop_q  <= 1'b0;
            adv_q  <= '0;
            fsel_q <= '0;
            path_q <= `CTAS_PATH_MESSAGE_BOX;
        end else begin
            err_q <= abort_req_in && !act_q && bad_req;  // R3
            irq_q <= resolve;  // R1
            pop_q <= resolve && path_q == `CTAS_PATH_TXFIFO;  // R4
            adv_q <= (resolve && path_q == `CTAS_PATH_MPFIFO) ? fsel_q : '0;  // R3
            if (take) begin
                act_q  <= 1'b1;
                path_q <= abort_path_in;
                fsel_q <= NFIFO'(1) << abort_detail_in;
            end else if (resolve) begin
                act_q <= 1'b0;
            end
        end
    end

    assign transmit_request_flag_out  = treq_q;
    assign transmit_complete_flag_out = done_q;
    assign outcome_cancelled_out      = cnl_q;
    assign abort_busy_out             = act_q;
    assign abort_irq_out              = irq_q;
    assign abort_error_out            = err_q;
    assign mpf_advance_out            = adv_q;
    assign txf_pop_out                = pop_q;

    ////////////////////////////////////////////////////////////////////////////
    // Internal bus and pin routing.

    logic [NCH-1:0] rx_s1_q, rx_s2_q, rx_s3_q, rx_q;
    logic           ibus_q;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rx_s1_q <= '1;
            rx_s2_q <= '1;
            rx_s3_q <= '1;
            rx_q    <= '1;
            ibus_q  <= 1'b0;
        end else begin
            rx_s1_q <= can_rx_in;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
            rx_q    <= (rx_s2_q & rx_s3_q) | (rx_q & (rx_s2_q | rx_s3_q));
            if (ibus_exit_in)
                ibus_q <= 1'b0;
            else if (ibus_req_in && global_halt_mode_in)
                ibus_q <= 1'b1;  // R8
        end
    end

    logic st_run;
    // Dominant bits from any channel reach all channels, as on a wired-AND bus.
    wire ibus_level = &ch_tx_in;
    assign ch_rx_out       = ibus_q ? {NCH{ibus_level}} : rx_q;  // R7
    assign can_tx_out      = (ibus_q || st_run) ? '1 : ch_tx_in;  // R7 R10
    assign tx_allow_out    = !st_run;  // R10
    assign ibus_active_out = ibus_q;

    ////////////////////////////////////////////////////////////////////////////
    // RAM self test.

    localparam int CELLS_ALL = (PAGES - 1) * CELLS + LAST;
    localparam int PW        = $clog2(PAGES + 1);
    localparam int CW        = $clog2(CELLS + 1);

    logic [DW-1:0]      mem [CELLS_ALL];
    ctas_pkg::ctas_st_e st_q;
    logic [PW-1:0]      page_q;
    logic [CW-1:0]      cell_q;
    logic [DW-1:0]      pat_q;
    logic               fail_q;

    wire [31:0] addr      = 32'(page_q) * 32'(CELLS) + 32'(cell_q);
    wire        last_page = 32'(page_q) == PAGES - 1;
    wire        last_cell = 32'(cell_q) == (last_page ? LAST : CELLS) - 1;
    wire        last_pat  = pat_q[DW-1];
    wire        mismatch  = mem[addr] != pat_q;
    assign st_run = st_q != ctas_pkg::CTAS_ST_IDLE;

    always_ff @(posedge clk_in) begin
        if (st_q == ctas_pkg::CTAS_ST_WRITE)
            mem[addr] <= pat_q;  // R9
    end

    // Each cell is cleared first, then a single one walks from bit 0 upward.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_q   <= ctas_pkg::CTAS_ST_IDLE;
            page_q <= '0;
            cell_q <= '0;
            pat_q  <= '0;
            fail_q <= 1'b0;
        end else begin
            unique case (st_q)
                ctas_pkg::CTAS_ST_IDLE: begin
                    if (selftest_start_in && global_halt_mode_in) begin  // R11
                        st_q   <= ctas_pkg::CTAS_ST_WRITE;
                        page_q <= '0;
                        cell_q <= '0;
                        pat_q  <= '0;
                        fail_q <= 1'b0;
                    end
                end
                ctas_pkg::CTAS_ST_WRITE: begin
                    st_q <= ctas_pkg::CTAS_ST_CHECK;
                end
                ctas_pkg::CTAS_ST_CHECK: begin
                    if (mismatch)
                        fail_q <= 1'b1;  // R11
                    st_q  <= ctas_pkg::CTAS_ST_WRITE;
                    pat_q <= (pat_q == '0) ? DW'(1) : pat_q << 1;  // R9
                    if (last_pat) begin
                        pat_q  <= '0;
                        cell_q <= last_cell ? '0 : cell_q + CW'(1);
                        if (last_cell) begin
                            page_q <= page_q + PW'(1);  // R9
                            if (last_page)
                                st_q <= ctas_pkg::CTAS_ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    assign selftest_busy_out = st_run;
    assign selftest_fail_out = fail_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    sequence s_abort_box_one;
        abort_req_in && !act_q && is_box && !abort_any_in;
    endsequence

    a_irq_on_resolve:  assert property (abort_irq_out |-> $past(act_q) && !act_q) else $error("irq without done"); // R1
    a_box_one_cancel:  assert property (s_abort_box_one ##0 (treq_q[abort_detail_in] && !tx_busy_in[abort_detail_in] && !tx_set_in[abort_detail_in]) |=> !treq_q[$past(abort_detail_in)]) else $error("buffer kept"); // R2
    a_mpf_wildcard:    assert property (abort_req_in && !act_q && is_mpf && abort_any_in |=> abort_error_out && !act_q) else $error("wildcard fifo taken"); // R3
    a_txf_pop_after:   assert property (txf_pop_out |-> $past(act_q) && path_q == `CTAS_PATH_TXFIFO) else $error("stray pop"); // R4
    a_sent_sets_done:  assert property (tx_sent_in[0] && treq_q[0] && !tx_set_in[0] |=> done_q[0] && !treq_q[0]) else $error("complete flag"); // R5
    a_ibus_silent:     assert property (ibus_q |-> can_tx_out == '1 && ch_rx_out == {NCH{ibus_level}}) else $error("ibus leak"); // R7
    a_ibus_halt_entry: assert property ($rose(ibus_q) |-> $past(global_halt_mode_in)) else $error("ibus outside halt"); // R8
    a_test_silent:     assert property (st_run |-> !tx_allow_out && can_tx_out == '1) else $error("traffic in test"); // R10
    a_test_halt_entry: assert property ($rose(st_run) |-> $past(global_halt_mode_in) ##1 st_q == ctas_pkg::CTAS_ST_CHECK) else $error("test start"); // R11
    a_fail_mismatch:   assert property (st_q == ctas_pkg::CTAS_ST_CHECK && mismatch |=> fail_q) else $error("miss lost"); // R11
    a_busy_finishes:   assert property (pend_q[0] && tx_busy_in[0] |=> treq_q[0] || done_q[0]) else $error("busy frame cut"); // R14

endmodule
`default_nettype wire

// ### verification/ctas_bus_node.sv
`timescale 1ns/1ns
`default_nettype none
// Other nodes on the shared bus. The line is wired-AND, so one dominant node pulls every pin low.
module ctas_bus_node #(
    parameter int NCH = 2
) (
    input  wire logic [NCH-1:0] can_tx_in,
    input  wire logic           node_dom_in,
    output logic      [NCH-1:0] bus_out
);
    assign bus_out = can_tx_in & {NCH{~node_dom_in}};
endmodule
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic       clk_in = 1'h0, arst_n_in = 1'h0, global_halt_mode_in = 1'h0, node_dom = 1'h0;
    logic       abort_req_in = 1'h0, abort_any_in = 1'h0, ibus_req_in = 1'h0, ibus_exit_in = 1'h0;
    logic       selftest_start_in = 1'h0;
    logic [7:0] tx_set_in = 8'h00, tx_busy_in = 8'h00, tx_sent_in = 8'h00;
    logic [1:0] abort_path_in = 2'h0, ch_tx_in = 2'h3;
    logic [2:0] abort_detail_in = 3'h0, txf_front_in = 3'h0;
    logic [5:0] mpf_buf_in = 6'h00;
    logic [4:0] ev;
    wire  [1:0] can_rx_in, ch_rx_out, can_tx_out, mpf_advance_out;
    wire  [7:0] transmit_request_flag_out, transmit_complete_flag_out, outcome_cancelled_out;
    wire        abort_busy_out, abort_irq_out, abort_error_out, txf_pop_out, ibus_active_out;
    wire        tx_allow_out, selftest_busy_out, selftest_fail_out;
    int         err_count = 0, compares = 0;
    // Small self test geometry keeps the walk short: 6 cells of 18 cycles.
    ctas_abort_selftest #(.PAGES(2), .CELLS(4), .LAST(2), .DW(8)) DUT (.clk_in, .arst_n_in,
        .global_halt_mode_in, .tx_set_in, .tx_busy_in, .tx_sent_in, .abort_req_in, .abort_path_in,
        .abort_any_in, .abort_detail_in, .mpf_buf_in, .txf_front_in, .ibus_req_in, .ibus_exit_in,
        .selftest_start_in, .ch_tx_in, .can_rx_in, .transmit_request_flag_out, .transmit_complete_flag_out,
        .outcome_cancelled_out, .abort_busy_out, .abort_irq_out, .abort_error_out, .mpf_advance_out,
        .txf_pop_out, .ibus_active_out, .tx_allow_out, .ch_rx_out, .can_tx_out, .selftest_busy_out,
        .selftest_fail_out);
    ctas_bus_node #(.NCH(2)) NODE (.can_tx_in(can_tx_out), .node_dom_in(node_dom), .bus_out(can_rx_in));
    always #5 clk_in = ~clk_in;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step();
        @(posedge clk_in);
        #1;
    endtask
    task automatic set_bufs(input logic [7:0] m);
        tx_set_in = m;
        step();
        tx_set_in = 8'h00;
    endtask
    // Pulses are one cycle wide, so every cycle is sampled and the events are collected.
    task automatic wait_ev();
        ev = 5'h00;
        for (int n = 0; n < 20 && !(ev[0] | ev[4]); n++) begin
            ev = ev | {abort_error_out, txf_pop_out, mpf_advance_out, abort_irq_out};
            step();
        end
    endtask
    task automatic abort(input logic [1:0] p, input logic a, input logic [2:0] d);
        abort_path_in = p;
        abort_any_in = a;
        abort_detail_in = d;
        abort_req_in = 1'h1;
        step();
        abort_req_in = 1'h0;
        wait_ev();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_msgbox();
        set_bufs(8'h14);
        abort(2'h0, 1'h0, 3'h2);
        chk(ev, 5'h01);
        chk(transmit_request_flag_out, 8'h10);
        chk(outcome_cancelled_out, 8'h04);
        tx_sent_in = 8'h10;
        step();
        tx_sent_in = 8'h00;
        step();
        chk(transmit_complete_flag_out, 8'h10);
        set_bufs(8'hFF);
        abort(2'h0, 1'h1, 3'h0);
        chk(outcome_cancelled_out, 8'hFF);
        chk(transmit_request_flag_out, 8'h00);
        $display("test msgbox done");
    endtask
    task automatic t_busy();
        set_bufs(8'h02);
        tx_busy_in = 8'h02;
        abort(2'h0, 1'h0, 3'h1);
        chk(ev[0], 1'h0);
        chk(transmit_request_flag_out, 8'h02);
        chk({abort_busy_out, transmit_complete_flag_out[1], outcome_cancelled_out[1]}, 3'h4);
        tx_sent_in = 8'h02;
        step();
        tx_sent_in = 8'h00;
        tx_busy_in = 8'h00;
        wait_ev();
        chk(ev[0], 1'h1);
        chk(transmit_complete_flag_out, 8'h02);
        chk(outcome_cancelled_out, 8'hFD);
        // A frame that leaves the bus without being sent counts as withdrawn.
        set_bufs(8'h08);
        tx_busy_in = 8'h08;
        abort(2'h0, 1'h0, 3'h3);
        tx_busy_in = 8'h00;
        wait_ev();
        chk({ev[0], transmit_request_flag_out[3]}, 2'h2);
        chk({outcome_cancelled_out[3], transmit_complete_flag_out[3]}, 2'h2);
        $display("test busy done");
    endtask
    task automatic t_fifo();
        mpf_buf_in = {3'h4, 3'h0};
        txf_front_in = 3'h5;
        set_bufs(8'h30);
        abort(2'h1, 1'h0, 3'h1);
        chk({ev, outcome_cancelled_out[5:4]}, 7'h15);
        abort(2'h2, 1'h0, 3'h7);
        chk({ev, outcome_cancelled_out[5:4]}, 7'h27);
        for (int i = 0; i < 3; i++) begin
            abort(i == 2 ? 2'h3 : 2'h1, i == 0, 3'h2);
            chk(ev, 5'h10);
        end
        $display("test fifo done");
    endtask
    task automatic t_ibus();
        set_bufs(8'h0C);
        abort(2'h0, 1'h1, 3'h0);
        chk({ev, transmit_request_flag_out}, 13'h0100);
        ibus_req_in = 1'h1;
        step();
        ibus_req_in = 1'h0;
        step();
        chk(ibus_active_out, 1'h0);
        global_halt_mode_in = 1'h1;
        ch_tx_in = 2'h2;
        ibus_req_in = 1'h1;
        step();
        ibus_req_in = 1'h0;
        step();
        chk({ibus_active_out, can_tx_out, ch_rx_out}, 5'h1C);
        // A dominant outside node must not reach the channels while they are linked internally.
        ch_tx_in = 2'h3;
        node_dom = 1'h1;
        repeat (5) step();
        chk({ibus_active_out, can_tx_out, ch_rx_out}, 5'h1F);
        node_dom = 1'h0;
        ch_tx_in = 2'h2;
        ibus_exit_in = 1'h1;
        step();
        ibus_exit_in = 1'h0;
        repeat (6) step();
        chk({ibus_active_out, can_tx_out, ch_rx_out}, 5'h0A);
        $display("test ibus done");
    endtask
    task automatic t_selftest();
        int cnt;
        cnt = 0;
        ch_tx_in = 2'h0;
        global_halt_mode_in = 1'h0;
        selftest_start_in = 1'h1;
        step();
        selftest_start_in = 1'h0;
        step();
        chk(selftest_busy_out, 1'h0);
        global_halt_mode_in = 1'h1;
        selftest_start_in = 1'h1;
        step();
        selftest_start_in = 1'h0;
        step();
        chk({tx_allow_out, can_tx_out}, 3'h3);
        while (selftest_busy_out === 1'h1 && cnt < 1000) begin
            cnt++;
            step();
        end
        chk(cnt >= 107 && cnt <= 109, 1'h1);
        chk({selftest_fail_out, tx_allow_out}, 2'h1);
        global_halt_mode_in = 1'h0;
        ch_tx_in = 2'h3;
        set_bufs(8'h01);
        chk({transmit_request_flag_out, tx_allow_out, can_tx_out}, 11'h00F);
        arst_n_in = 1'h0;
        step();
        arst_n_in = 1'h1;
        chk({transmit_request_flag_out, selftest_fail_out}, 9'h000);
        $display("test selftest done");
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) step();
        arst_n_in = 1'h1;
        chk({transmit_request_flag_out, outcome_cancelled_out, tx_allow_out, can_tx_out}, 19'h00007);
        t_msgbox();
        t_busy();
        t_fifo();
        t_ibus();
        t_selftest();
        report_and_stop();
    end
    // The tests need well under 2000 cycles; this margin only catches a hang.
    initial begin
        #100000;
        err_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
